// File: core/rdpsc_top.sv
// What this block does
// - Enable low holds power-down, power outputs driven low
// - Power-on starts in reset state, chip off
// - Reset release, first low power, 2ms, second
// - Hot-plug high in second low power: active
// - Regulator on in active; channels after good
// - Hot-plug low: wait; 300ms low returns low-power
// - Hot-plug back high within 300ms: active again
// - Wait state powers same blocks as active
// - DP mode powers off lanes not trained
// - No input video powers down channels and high-speed outputs
// - No monitor detected powers down chip
// - Link-config power-down request enters power-down
// - Channels off unless active/wait and lane decoded
// - Inactive channels stay off even with adapter
// - Cable-detect high selects TMDS, stops aux intercept
module rdpsc_top import rdpsc_pkg::*; #(
    parameter int unsigned LANES = NUM_LANES,
    parameter int unsigned DWELL_CYCLES = LPM_DWELL_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Board controller
    input wire logic enable_pin,
    // Sink side pins
    input wire logic sink_hot_plug_pin,
    input wire logic sink_cable_detect,
    // Internal status from analog and link logic
    input wire logic reg_1v2_good,
    input wire logic [LANES-1:0] lane_select_decode,
    input wire logic video_present,
    input wire logic link_power_down_req,
    // Power controls
    output logic reg_1v2_en,
    output logic [LANES-1:0] lane_reg_en,
    output logic [LANES-1:0] lane_rx_en,
    output logic [LANES-1:0] lane_tx_en,
    output logic hs_out_en,
    // Source side and mode
    output logic source_hot_plug_out,
    output logic tmds_mode,
    output logic aux_intercept_en,
    output logic [2:0] power_state
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // Reset released through two flops so release is clean on clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // Pin and cross-domain inputs
    logic [4:0] pins_raw;
    logic [4:0] pins_s;
    logic enable_s;
    logic hpd_s;
    logic cad_s;
    logic pg_s;
    logic video_s;

    assign pins_raw = {video_present, reg_1v2_good, sink_cable_detect,
                       sink_hot_plug_pin, enable_pin};

    rdpsc_sync #(.WIDTH(5)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign enable_s = pins_s[0];
    assign hpd_s = pins_s[1];
    assign cad_s = pins_s[2];
    assign pg_s = pins_s[3];
    assign video_s = pins_s[4];

    // Enable low or a link power-down request forces the reset state
    logic force_down;
    assign force_down = !enable_s || link_power_down_req;

    rdpsc_state_t state_q;
    rdpsc_state_t state_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_d;

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        if (force_down) begin
            state_d = state_power_on_reset;
            timer_d = TIMER_RESET;
        end else begin
            case (state_q)
                state_power_on_reset: begin
                    state_d = state_low_power_first;
                    timer_d = TIMER_RESET;
                end
                state_low_power_first: begin
                    if (timer_q >= TIMER_W'(DWELL_CYCLES - 1)) begin
                        state_d = state_low_power_second;
                        timer_d = TIMER_RESET;
                    end else begin
                        timer_d = timer_q + 1'b1;
                    end
                end
                state_low_power_second: begin
                    if (hpd_s) begin
                        state_d = state_active;
                    end
                end
                state_active: begin
                    if (!hpd_s) begin
                        state_d = state_active_wait;
                        timer_d = TIMER_RESET;
                    end
                end
                state_active_wait: begin
                    if (hpd_s) begin
                        state_d = state_active;
                    end else if (timer_q >= TIMER_W'(DEBOUNCE_CYCLES - 1)) begin
                        state_d = state_low_power_second;
                    end else begin
                        timer_d = timer_q + 1'b1;
                    end
                end
                default: begin
                    state_d = state_power_on_reset;
                    timer_d = TIMER_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= state_power_on_reset;
            timer_q <= TIMER_RESET;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
        end
    end

    // Active and wait look alike to every power control and to the run-state checks
    function automatic logic is_run_state(rdpsc_state_t s);
        return (s == state_active) || (s == state_active_wait);
    endfunction

    // Output power controls, registered so they are glitch free
    logic in_run;
    logic chip_on;
    assign in_run = is_run_state(state_q);
    // Monitor presence is the hot-plug level; drops are ridden out by the wait state
    assign chip_on = in_run && video_s;

    logic reg_en_q;
    logic reg_en_d;
    logic [LANES-1:0] lreg_q;
    logic [LANES-1:0] lreg_d;
    logic [LANES-1:0] chan_q;
    logic [LANES-1:0] chan_d;
    logic hs_q;
    logic hs_d;
    logic hpd_out_q;
    logic hpd_out_d;
    logic tmds_q;
    logic tmds_d;

    always_comb begin
        reg_en_d = in_run;
        // Only lanes that training selected are powered in either mode
        lreg_d = in_run ? lane_select_decode : LANE_RESET;
        chan_d = (chip_on && pg_s && reg_en_q) ? (lreg_q & lane_select_decode)
                                               : LANE_RESET;
        hs_d = chip_on && pg_s;
        hpd_out_d = in_run;
        tmds_d = cad_s;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_en_q <= 1'b0;
            lreg_q <= LANE_RESET;
            chan_q <= LANE_RESET;
            hs_q <= 1'b0;
            hpd_out_q <= 1'b0;
            tmds_q <= 1'b0;
        end else begin
            reg_en_q <= reg_en_d;
            lreg_q <= lreg_d;
            chan_q <= chan_d;
            hs_q <= hs_d;
            hpd_out_q <= hpd_out_d;
            tmds_q <= tmds_d;
        end
    end

    assign reg_1v2_en = reg_en_q;
    assign lane_reg_en = lreg_q;
    assign lane_rx_en = chan_q;
    assign lane_tx_en = chan_q;
    assign hs_out_en = hs_q;
    assign source_hot_plug_out = hpd_out_q;
    assign tmds_mode = tmds_q;
    assign aux_intercept_en = !tmds_q && reg_en_q;
    assign power_state = state_q;

    // Checks
    a_disable_forces_reset: assert property (@(posedge clock) disable iff (!rst_n)
        !enable_s |=> state_q == state_power_on_reset)
        else $error("enable low did not force reset state");
    a_outputs_off_disabled: assert property (@(posedge clock) disable iff (!rst_n)
        !enable_s ##1 !enable_s |=> !hs_out_en && lane_tx_en == LANE_RESET)
        else $error("outputs active while disabled");
    a_reset_to_lpm1: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_power_on_reset && !force_down |=> state_q == state_low_power_first)
        else $error("reset state did not advance");
    a_lpm1_dwell: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(state_q == state_low_power_first) |-> timer_q == TIMER_RESET)
        else $error("dwell timer not cleared on entry");
    a_hpd_to_active: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_low_power_second && hpd_s && !force_down |=> state_q == state_active)
        else $error("hot-plug did not activate");
    a_regulator_active: assert property (@(posedge clock) disable iff (!rst_n)
        in_run && !force_down |=> reg_1v2_en)
        else $error("regulator off while running");
    a_channel_needs_good: assert property (@(posedge clock) disable iff (!rst_n)
        lane_rx_en != LANE_RESET |-> $past(pg_s) && $past(reg_en_q))
        else $error("channel on before supply good");
    a_drop_to_wait: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_active && !hpd_s && !force_down |=> state_q == state_active_wait)
        else $error("hot-plug drop not debounced");
    a_wait_returns: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_active_wait && hpd_s && !force_down |=> state_q == state_active)
        else $error("wait did not return to active");
    a_lane_mask: assert property (@(posedge clock) disable iff (!rst_n)
        (lane_rx_en & ~lane_reg_en) == LANE_RESET)
        else $error("channel powered without its regulator");
    a_tmds_follows_cad: assert property (@(posedge clock) disable iff (!rst_n)
        cad_s |=> tmds_mode && !aux_intercept_en)
        else $error("adapter did not select alternate mode");

    // Sequencing and power checks
    a_low_states_dark: assert property (@(posedge clock) disable iff (!rst_n)
        !is_run_state(state_q) |=> lane_reg_en == '0 && lane_rx_en == '0)
        else $error("lane powered outside active and wait");
    a_reset_chip_off: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_power_on_reset |=> !reg_1v2_en && !hs_out_en)
        else $error("chip powered in reset state");
    a_low1_entry: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_low_power_first |->
            $past(state_q) == state_power_on_reset || $past(state_q) == state_low_power_first)
        else $error("first low power entered from wrong state");
    a_low1_holds: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_low_power_first && !force_down &&
            timer_q < TIMER_W'(DWELL_CYCLES - 1) |=> state_q == state_low_power_first)
        else $error("first low power left early");
    a_low1_expiry: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_low_power_first && !force_down &&
            timer_q == TIMER_W'(DWELL_CYCLES - 1) |=> state_q == state_low_power_second)
        else $error("first low power overstayed");
    a_low2_holds: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_low_power_second && !hpd_s && !force_down
            |=> state_q == state_low_power_second)
        else $error("second low power left without hot-plug");
    a_debounce_holds: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_active_wait && !hpd_s && !force_down &&
            timer_q < TIMER_W'(DEBOUNCE_CYCLES - 1) |=> state_q == state_active_wait)
        else $error("debounce ended early");
    a_debounce_expiry: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_active_wait && !hpd_s && !force_down &&
            timer_q == TIMER_W'(DEBOUNCE_CYCLES - 1) |=> state_q == state_low_power_second)
        else $error("debounce expiry did not return to low power");
    a_debounce_restart: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(state_q == state_active_wait) |-> timer_q == TIMER_RESET)
        else $error("debounce timer not cleared on wait entry");
    a_wait_keeps_power: assert property (@(posedge clock) disable iff (!rst_n)
        state_q == state_active_wait |=> reg_1v2_en && lane_reg_en == $past(lane_select_decode))
        else $error("wait state dropped power");
    a_source_hpd_run: assert property (@(posedge clock) disable iff (!rst_n)
        source_hot_plug_out == $past(is_run_state(state_q)))
        else $error("source hot-plug does not follow run states");
    a_no_video_dark: assert property (@(posedge clock) disable iff (!rst_n)
        !video_s |=> lane_rx_en == '0 && !hs_out_en)
        else $error("channels on without input video");
    a_supply_bad_dark: assert property (@(posedge clock) disable iff (!rst_n)
        !pg_s |=> lane_rx_en == '0 && !hs_out_en)
        else $error("channels on without good supply");
    a_lanes_in_decode: assert property (@(posedge clock) disable iff (!rst_n)
        lane_tx_en == lane_rx_en && (lane_rx_en & ~$past(lane_select_decode)) == '0)
        else $error("unselected lane powered");
    a_power_down_req: assert property (@(posedge clock) disable iff (!rst_n)
        link_power_down_req |=> state_q == state_power_on_reset)
        else $error("power-down request ignored");
    a_dp_mode_aux: assert property (@(posedge clock) disable iff (!rst_n)
        !cad_s && is_run_state(state_q) |=> !tmds_mode && aux_intercept_en)
        else $error("no adapter but aux intercept off");
endmodule // rdpsc_top

// File: core/rdpsc_pkg.sv
package rdpsc_pkg;
    // Interval lengths, and the clock rate they are counted at
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned LPM_DWELL_US = 2000;
    localparam int unsigned DEBOUNCE_MS = 300;
    localparam int unsigned LPM_DWELL_CYC = LPM_DWELL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned NUM_LANES = 4;
    localparam int unsigned TIMER_W = 24;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 24'h000000;
    localparam logic [3:0] LANE_RESET = 4'h0;

    typedef enum logic [2:0] {
        state_power_on_reset,
        state_low_power_first,
        state_low_power_second,
        state_active,
        state_active_wait
    } rdpsc_state_t;
endpackage

// File: core/rdpsc_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
module rdpsc_sync import rdpsc_pkg::*; #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // rdpsc_sync

// File: testbench/rdpsc_board_model.sv
// Board controller and sink as seen from the sequencer's pins
module rdpsc_board_model #(
    parameter int unsigned RESET_LOW_CYC = 2500
) (
    // Clock
    input wire logic clock,
    // Commands from the bench
    input wire logic supply_ok,
    input wire logic reset_req,
    input wire logic hpd_req,
    // Pins
    output logic enable_pin,
    output logic sink_hot_plug_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned low_cnt;
    initial begin
        enable_pin = 1'b0;
        low_cnt = RESET_LOW_CYC;
    end
    always @(posedge clock) begin
        if (!supply_ok || reset_req) begin
            enable_pin <= #2 1'b0;
            low_cnt <= RESET_LOW_CYC;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end else begin
            enable_pin <= #2 1'b1;
        end
    end
    // No programmed configuration here, so nothing is rewritten after reset
    assign sink_hot_plug_pin = hpd_req;
endmodule // rdpsc_board_model

// File: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rdpsc_pkg::*;
    localparam int DW = 20;
    localparam int DB = 50;
    logic clock = 0, arst_n = 1, supply_ok = 0, reset_req = 0, hpd_req = 0;
    logic sink_cable_detect = 0, reg_1v2_good = 0, video_present = 0, link_power_down_req = 0;
    logic [3:0] lane_select_decode = 4'h0;
    logic enable_pin, sink_hot_plug_pin, reg_1v2_en, hs_out_en;
    logic source_hot_plug_out, tmds_mode, aux_intercept_en;
    logic [3:0] lane_reg_en, lane_rx_en, lane_tx_en;
    logic [2:0] power_state;
    int n_mismatch = 0;
    int compares = 0;
    int n;
    logic [31:0] seed = 32'h48BB4FE6;
    always #20 clock = ~clock;
    rdpsc_board_model board_u (.clock, .supply_ok, .reset_req, .hpd_req, .enable_pin,
        .sink_hot_plug_pin);
    rdpsc_top #(.LANES(4), .DWELL_CYCLES(DW), .DEBOUNCE_CYCLES(DB)) dut_u (.clock, .arst_n,
        .enable_pin, .sink_hot_plug_pin, .sink_cable_detect, .reg_1v2_good, .lane_select_decode,
        .video_present, .link_power_down_req, .reg_1v2_en, .lane_reg_en, .lane_rx_en,
        .lane_tx_en, .hs_out_en, .source_hot_plug_out, .tmds_mode, .aux_intercept_en,
        .power_state);
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [3:0] exp_lanes(logic on, logic [3:0] dec);
        return on ? dec : 4'h0;
    endfunction
    task automatic cmp(logic [3:0] got, logic [3:0] exp, string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_state(rdpsc_state_t exp);
        compares++;
        if (power_state !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: state %0d expected %0d", $time, power_state, exp);
        end
    endtask
    task automatic step(int k);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task automatic wait_state(rdpsc_state_t s, int lim);
        n = 0;
        while (power_state !== s && n < lim) begin
            step(1);
            n++;
        end
        cmp_state(s);
    endtask
    task automatic chk_lanes(logic reg_on, logic ch_on);
        cmp(lane_reg_en, exp_lanes(reg_on, lane_select_decode), "lane regulators");
        cmp(lane_rx_en, exp_lanes(ch_on, lane_select_decode), "lane receivers");
        cmp(lane_tx_en, exp_lanes(ch_on, lane_select_decode), "lane transmitters");
    endtask
    task automatic stop_test;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        // A real falling edge clears every flop before the first clock
        #1 arst_n = 1'b0;
        step(8);
        arst_n = 1'b1;
        step(4);
        cmp_state(state_power_on_reset);
        cmp({3'h0, hs_out_en}, 4'h0, "outputs idle");
        supply_ok = 1'b1;
        wait_state(state_low_power_first, 2600);
        wait_state(state_low_power_second, DW + 4);
        cmp(4'(n == DW), 4'h1, "dwell length");
        step(5);
        cmp_state(state_low_power_second);
        hpd_req = 1'b1;
        wait_state(state_active, 6);
        video_present = 1'b1;
        lane_select_decode = 4'hF;
        step(4);
        cmp({3'h0, reg_1v2_en}, 4'h1, "regulator on");
        chk_lanes(1'b1, 1'b0);
        cmp({3'h0, hs_out_en}, 4'h0, "outputs wait for good");
        cmp({3'h0, source_hot_plug_out}, 4'h1, "source hot-plug active");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            lane_select_decode = (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : seed[3:0];
            reg_1v2_good = seed[4] | (i > 2);
            sink_cable_detect = seed[5];
            step(8);
            chk_lanes(1'b1, reg_1v2_good);
            cmp({3'h0, tmds_mode}, {3'h0, seed[5]}, "tmds mode");
            cmp({3'h0, aux_intercept_en}, {3'h0, !seed[5]}, "aux intercept");
            cmp({3'h0, hs_out_en}, {3'h0, reg_1v2_good}, "outputs follow supply");
        end
        video_present = 1'b0;
        step(8);
        cmp(lane_rx_en, 4'h0, "no video channels");
        cmp({3'h0, hs_out_en}, 4'h0, "no video outputs");
        video_present = 1'b1;
        sink_cable_detect = 1'b0;
        lane_select_decode = 4'hF;
        reg_1v2_good = 1'b1;
        step(8);
        hpd_req = 1'b0;
        wait_state(state_active_wait, 6);
        step(DB / 2);
        cmp_state(state_active_wait);
        chk_lanes(1'b1, 1'b1);
        cmp({3'h0, reg_1v2_en}, 4'h1, "wait regulator");
        hpd_req = 1'b1;
        wait_state(state_active, 6);
        hpd_req = 1'b0;
        wait_state(state_active_wait, 6);
        wait_state(state_low_power_second, DB + 6);
        cmp(4'(n == DB), 4'h1, "debounce restarted");
        step(4);
        chk_lanes(1'b0, 1'b0);
        cmp({3'h0, source_hot_plug_out}, 4'h0, "source hot-plug idle");
        hpd_req = 1'b1;
        wait_state(state_active, 8);
        link_power_down_req = 1'b1;
        wait_state(state_power_on_reset, 6);
        step(3);
        chk_lanes(1'b0, 1'b0);
        link_power_down_req = 1'b0;
        wait_state(state_active, DW + 12);
        reset_req = 1'b1;
        step(1);
        reset_req = 1'b0;
        wait_state(state_power_on_reset, 8);
        step(3);
        cmp({3'h0, hs_out_en}, 4'h0, "enable low outputs");
        wait_state(state_active, 2600 + DW + 20);
        stop_test();
    end
    initial begin
        #(40 * 12000);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench
